// ==== design/fault_retry_defines.svh ====
// timing counts and field positions for the fault retry logic
`ifndef FAULT_RETRY_DEFINES_SVH
`define FAULT_RETRY_DEFINES_SVH

// ----------------------------------------
// response byte fields
// ----------------------------------------
`define RETRY_FIELD_HI 5
`define RETRY_FIELD_LO 3
`define DELAY_FIELD_HI 2
`define DELAY_FIELD_LO 0
`define RETRY_NONE 3'h0

// ----------------------------------------
// delay unit and clock
// ----------------------------------------
`define CLOCK_PERIOD_NS 100
`define DELAY_UNIT_NS 1000
`define DELAY_UNIT_CYCLES ((`DELAY_UNIT_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// ==== design/fault_retry_pkg.sv ====
// types shared by the fault retry logic
`default_nettype none
package fault_retry_pkg;

	// response byte as carried on the port
	typedef struct packed {
		logic [1:0] spare;
		logic [2:0] retries;
		logic [2:0] delay;
	} response_type;

	// host side controls travelling together
	typedef struct packed {
		logic clear_faults;
		logic ctrl_pin_on;
		logic operation_on;
	} host_ctrl_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RUN,
		ST_WAIT,
		ST_LATCHED
	} retry_state_type;

endpackage
`default_nettype wire

// ==== design/fault_retry_response.sv ====
// fault response retry controller of a managed power converter
`default_nettype none
`timescale 1ns/100ps
`include "fault_retry_defines.svh"

module fault_retry_response
	import fault_retry_pkg::*;
#(
	parameter int UNIT_CYCLES = `DELAY_UNIT_CYCLES
)
(
	input wire logic MCLK_IN,
	input wire logic RST_N_IN,
	input wire logic FAULT_IN,
	input wire fault_retry_pkg::response_type RESPONSE_IN,
	input wire fault_retry_pkg::host_ctrl_type HOST_IN,
	output logic OUTPUT_EN_OUT,
	output logic FAULT_LATCHED_OUT,
	output logic RETRY_ACTIVE_OUT,
	output logic [2:0] ATTEMPTS_OUT
);
	import fault_retry_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	retry_state_type state_ff, nxt_state;
	logic [2:0] attempts_ff, nxt_attempts;
	logic on_cmd_prev_ff;
	logic cycled_off_ff, nxt_cycled_off;
	logic en_ff, latched_ff, retry_ff;
	logic timer_start;
	logic timer_done;

	// ----------------------------------------
	// decoding
	// ----------------------------------------
	// output is wanted only when pin and operation both say on
	wire on_cmd = HOST_IN.ctrl_pin_on & HOST_IN.operation_on;
	// last edge's on command, for finding the rising edge
	wire on_prev_ok = on_cmd_prev_ff;
	wire on_rise = on_cmd & ~on_prev_ok;
	wire power_cycle = on_rise & cycled_off_ff;
	wire clear_req = HOST_IN.clear_faults | power_cycle;
	// fields 4 to 7 are not defined; they simply allow that many restarts
	wire [2:0] retry_limit = RESPONSE_IN.retries;
	wire no_retry = (retry_limit == `RETRY_NONE);
	wire retries_left = (attempts_ff < retry_limit);

	// ----------------------------------------
	// state decoding
	// ----------------------------------------
	// present state flags
	wire in_run = (state_ff == ST_RUN);
	// a fault while the output is up drops it at the same edge
	wire run_fault = in_run & FAULT_IN;
	// next state flags feed the output flip-flops directly
	wire going_run = (nxt_state == ST_RUN);
	wire going_wait = (nxt_state == ST_WAIT);
	wire going_latched = (nxt_state == ST_LATCHED);

	// ----------------------------------------
	// spacing timer
	// ----------------------------------------
	// the wait is timed from the fault, so it covers the off time before a restart
	// attempt spacing
	retry_delay_timer #(.UNIT_CYCLES(UNIT_CYCLES)) retry_delay_timer_i
	(
		.clk_in(MCLK_IN),
		.rst_n_in(RST_N_IN),
		.start_in(timer_start),
		.delay_in(RESPONSE_IN.delay),
		.done_out(timer_done)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	// clear wins over timer expiry; a fault still present after a clear is retried afresh
	always_comb
	begin
		nxt_state = state_ff;
		nxt_attempts = attempts_ff;
		timer_start = 1'b0;
		nxt_cycled_off = cycled_off_ff;
		if (!on_cmd)
			nxt_cycled_off = 1'b1;
		case (state_ff)
			ST_IDLE:
			begin
				nxt_cycled_off = 1'b0;
				nxt_attempts = 3'h0;
				if (on_cmd)
					nxt_state = ST_RUN;
			end
			ST_RUN:
			begin
				if (!on_cmd)
					nxt_state = ST_IDLE;
				else if (FAULT_IN)
				begin
					if (no_retry || !retries_left)
					begin
						nxt_state = ST_LATCHED;
						nxt_cycled_off = 1'b0;
					end
					else
					begin
						nxt_state = ST_WAIT;
						nxt_attempts = attempts_ff + 3'h1;
						timer_start = 1'b1;
						nxt_cycled_off = 1'b0;
					end
				end
				// a clear while running resets the count, a fault wins
				else if (HOST_IN.clear_faults)
					nxt_attempts = 3'h0;
			end
			ST_WAIT:
			begin
				if (clear_req)
				begin
					nxt_attempts = 3'h0;
					nxt_state = on_cmd ? ST_RUN : ST_IDLE;
				end
				else if (timer_done)
					nxt_state = ST_RUN;
			end
			ST_LATCHED:
			begin
				if (clear_req)
				begin
					nxt_attempts = 3'h0;
					nxt_state = on_cmd ? ST_RUN : ST_IDLE;
				end
			end
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// reset clears fault and count
	always_ff @(posedge MCLK_IN)
	begin
		if (!RST_N_IN)
		begin
			state_ff <= ST_IDLE;
			attempts_ff <= 3'h0;
		end
		else
		begin
			state_ff <= nxt_state;
			attempts_ff <= nxt_attempts;
		end
	end

	// command history for the off-then-on detection
	always_ff @(posedge MCLK_IN)
	begin
		if (!RST_N_IN)
		begin
			on_cmd_prev_ff <= 1'b0;
			cycled_off_ff <= 1'b0;
		end
		else
		begin
			on_cmd_prev_ff <= on_cmd;
			cycled_off_ff <= nxt_cycled_off;
		end
	end

	// output enable, dropped in the same edge as a fault
	always_ff @(posedge MCLK_IN)
	begin
		if (!RST_N_IN)
			en_ff <= 1'b0;
		else
			en_ff <= going_run & ~run_fault;
	end

	// latched flag follows the next state
	always_ff @(posedge MCLK_IN)
	begin
		if (!RST_N_IN)
			latched_ff <= 1'b0;
		else
			latched_ff <= going_latched;
	end

	// retry flag high for the whole spacing wait
	always_ff @(posedge MCLK_IN)
	begin
		if (!RST_N_IN)
			retry_ff <= 1'b0;
		else
			retry_ff <= going_wait;
	end

	assign OUTPUT_EN_OUT = en_ff;
	assign FAULT_LATCHED_OUT = latched_ff;
	assign RETRY_ACTIVE_OUT = retry_ff;
	assign ATTEMPTS_OUT = attempts_ff;
endmodule // fault_retry_response
`default_nettype wire

// ==== design/retry_delay_timer.sv ====
// spacing timer between restart attempts
`default_nettype none
`timescale 1ns/100ps
`include "fault_retry_defines.svh"

module retry_delay_timer
#(
	parameter int UNIT_CYCLES = `DELAY_UNIT_CYCLES
)
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire logic [2:0] delay_in,
	output logic done_out
);
	logic [15:0] unit_cnt_ff;
	logic [2:0] units_ff;
	logic busy_ff;
	logic done_ff;
	wire unit_tick = (unit_cnt_ff == 16'(UNIT_CYCLES - 1));
	wire last_unit = (units_ff == 3'h0);

	// count whole delay units, zero units still gives one cycle
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			unit_cnt_ff <= 16'h0000;
			units_ff <= 3'h0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end
		else if (start_in)
		begin
			unit_cnt_ff <= 16'h0000;
			units_ff <= delay_in;
			busy_ff <= 1'b1;
			done_ff <= 1'b0;
		end
		else if (busy_ff)
		begin
			done_ff <= last_unit;
			busy_ff <= !last_unit;
			unit_cnt_ff <= unit_tick ? 16'h0000 : unit_cnt_ff + 16'h0001;
			if (unit_tick)
				units_ff <= units_ff - 3'h1;
		end
		else
			done_ff <= 1'b0;
	end

	assign done_out = done_ff;
endmodule // retry_delay_timer
`default_nettype wire

// ==== test/fault_retry_response_monitor.sv ====
// port assertions for the retry controller
`default_nettype none
`timescale 1ns/100ps
module fault_retry_response_monitor
	import fault_retry_pkg::*;
(
	input wire logic MCLK_IN,
	input wire logic RST_N_IN,
	input wire logic FAULT_IN,
	input wire fault_retry_pkg::response_type RESPONSE_IN,
	input wire fault_retry_pkg::host_ctrl_type HOST_IN,
	input wire logic OUTPUT_EN_OUT,
	input wire logic FAULT_LATCHED_OUT,
	input wire logic RETRY_ACTIVE_OUT,
	input wire logic [2:0] ATTEMPTS_OUT
);
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (!RST_N_IN);
	wire on_cmd = HOST_IN.ctrl_pin_on & HOST_IN.operation_on;
	property p_clr;
		FAULT_LATCHED_OUT && HOST_IN.clear_faults |=> !FAULT_LATCHED_OUT;
	endproperty
	a_clr: assert property (p_clr) else $error("clear ignored");
	property p_rst;
		@(posedge MCLK_IN) disable iff (1'b0) !RST_N_IN |=> !FAULT_LATCHED_OUT && !OUTPUT_EN_OUT;
	endproperty
	a_rst: assert property (p_rst) else $error("reset kept fault");
	property p_cyc;
		FAULT_LATCHED_OUT && $rose(on_cmd) |=> !FAULT_LATCHED_OUT;
	endproperty
	a_cyc: assert property (p_cyc) else $error("power cycle ignored");
	property p_off;
		FAULT_LATCHED_OUT |-> !OUTPUT_EN_OUT && !RETRY_ACTIVE_OUT;
	endproperty
	a_off: assert property (p_off) else $error("output on while latched");
	property p_last;
		on_cmd && OUTPUT_EN_OUT && FAULT_IN && ATTEMPTS_OUT >= RESPONSE_IN.retries |=> FAULT_LATCHED_OUT;
	endproperty
	a_last: assert property (p_last) else $error("no latch after retries");
	property p_try;
		on_cmd && OUTPUT_EN_OUT && FAULT_IN && ATTEMPTS_OUT < RESPONSE_IN.retries
			|=> RETRY_ACTIVE_OUT && ATTEMPTS_OUT == $past(ATTEMPTS_OUT) + 3'h1;
	endproperty
	a_try: assert property (p_try) else $error("retry not counted");
	property p_gap;
		$rose(RETRY_ACTIVE_OUT) && !HOST_IN.clear_faults && !$rose(on_cmd)
			|-> RETRY_ACTIVE_OUT[*2] ##[1:40] !RETRY_ACTIVE_OUT;
	endproperty
	a_gap: assert property (p_gap) else $error("spacing wrong");
	property p_cnt;
		$fell(FAULT_LATCHED_OUT) |-> ATTEMPTS_OUT == 3'h0;
	endproperty
	a_cnt: assert property (p_cnt) else $error("count kept");
	// main scenarios seen
	c_try: cover property (RETRY_ACTIVE_OUT ##1 !RETRY_ACTIVE_OUT);
	c_lat: cover property ($rose(FAULT_LATCHED_OUT));
	c_clr: cover property ($fell(FAULT_LATCHED_OUT));
endmodule // fault_retry_response_monitor
bind fault_retry_response fault_retry_response_monitor fault_retry_response_monitor_i (.MCLK_IN, .RST_N_IN,
	.FAULT_IN, .RESPONSE_IN, .HOST_IN, .OUTPUT_EN_OUT, .FAULT_LATCHED_OUT, .RETRY_ACTIVE_OUT, .ATTEMPTS_OUT);
`default_nettype wire

// ==== test/fault_retry_response_test.sv ====
// self-checking bench for the retry controller
`default_nettype none
`timescale 1ns/100ps
module fault_retry_response_test;
	import fault_retry_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic fault = 1'b0;
	logic on = 1'b0;
	logic clr = 1'b0;
	response_type resp = 8'h00;
	host_ctrl_type host;
	logic en, lat, act;
	logic [2:0] att;
	int num_errors = 0;
	int compares = 0;
	int waited;
	always #50 clk = ~clk;
	host_ctrl_model host_ctrl_model_i (.clk_in(clk), .on_in(on), .clr_in(clr), .host_out(host));
	fault_retry_response #(.UNIT_CYCLES(2)) fault_retry_response_i (.MCLK_IN(clk), .RST_N_IN(rst_n),
		.FAULT_IN(fault), .RESPONSE_IN(resp), .HOST_IN(host), .OUTPUT_EN_OUT(en),
		.FAULT_LATCHED_OUT(lat), .RETRY_ACTIVE_OUT(act), .ATTEMPTS_OUT(att));
	task chk(string n, logic [2:0] s, logic [2:0] e);
		compares++;
		if (s !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	task finish_test;
		if (num_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// one-cycle fault pulse, sampled after it lands
	task hit;
		@(posedge clk) fault <= 1'b1;
		@(posedge clk) fault <= 1'b0;
		#1;
	endtask
	// bounded wait for the output to come back
	task wait_en;
		for (waited = 0; waited < 99 && en !== 1'b1; waited++)
			cyc(1);
		if (en !== 1'b1)
		begin
			num_errors++;
			finish_test();
		end
	endtask
	task t_noretry;
		@(posedge clk) resp <= 8'h01;
		hit();
		chk("lat", lat, 1);
		cyc(6);
		chk("en", en, 0);
		@(posedge clk) clr <= 1'b1;
		@(posedge clk) clr <= 1'b0;
		cyc(1);
		chk("lat", lat, 0);
		wait_en();
	endtask
	task t_retry;
		@(posedge clk) resp <= 8'h1A;
		for (int k = 1; k <= 3; k++)
		begin
			hit();
			chk("act", act, 1);
			chk("att", att, 3'(k));
			wait_en();
			chk("gap", 3'(waited >= 5), 1);
		end
		hit();
		chk("lat", lat, 1);
		// off then on clears; pin and operation both drop
		@(posedge clk) on <= 1'b0;
		cyc(4);
		@(posedge clk) on <= 1'b1;
		cyc(3);
		chk("lat", lat, 0);
		chk("att", att, 0);
		wait_en();
	endtask
	task t_rst;
		@(posedge clk) resp <= 8'h00;
		hit();
		@(posedge clk) rst_n <= 1'b0;
		cyc(2);
		chk("lat", lat, 0);
		chk("en", en, 0);
		@(posedge clk) rst_n <= 1'b1;
		wait_en();
	endtask
	// clear in the wait, in the run and in the latch
	task t_clear;
		@(posedge clk) resp <= 8'h0F;
		hit();
		chk("act", act, 1);
		chk("att", att, 1);
		@(posedge clk) clr <= 1'b1;
		@(posedge clk) clr <= 1'b0;
		cyc(1);
		chk("act", act, 0);
		chk("att", att, 0);
		chk("en", en, 1);
		hit();
		chk("att", att, 1);
		wait_en();
		@(posedge clk) clr <= 1'b1;
		@(posedge clk) clr <= 1'b0;
		cyc(1);
		chk("att", att, 0);
		hit();
		chk("act", act, 1);
		wait_en();
		hit();
		chk("lat", lat, 1);
		@(posedge clk) clr <= 1'b1;
		@(posedge clk) clr <= 1'b0;
		cyc(1);
		chk("lat", lat, 0);
		wait_en();
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		on <= 1'b1;
		wait_en();
		t_noretry();
		t_retry();
		t_rst();
		t_clear();
		finish_test();
	end
endmodule // fault_retry_response_test
`default_nettype wire

// ==== test/host_ctrl_model.sv ====
// host controller model: clear and on commands
`default_nettype none
`timescale 1ns/100ps
module host_ctrl_model
	import fault_retry_pkg::*;
(
	input wire logic clk_in,
	input wire logic on_in,
	input wire logic clr_in,
	output var fault_retry_pkg::host_ctrl_type host_out
);
	initial host_out = '0;
	// pin leads, operation follows a cycle later
	always @(posedge clk_in)
	begin
		host_out.ctrl_pin_on <= on_in;
		host_out.operation_on <= host_out.ctrl_pin_on;
		host_out.clear_faults <= clr_in;
	end
endmodule // host_ctrl_model
`default_nettype wire
